// ---- bench/bus_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module bus_master_model #(
   parameter logic [6:0] DEV_ADDR = 7'h4c
) (
   input wire logic sda_wire,
   output logic scl_clk,
   output logic sda_drv
);
   localparam int HALF = 24;
   // clock stands high between frames, data released to pull-up
   initial begin
      scl_clk = 1'b1;
      sda_drv = 1'b1;
   end
   // ==========================
   // bus conditions and bytes, master clocks every transfer
   task automatic start_cond();
      #HALF;
      sda_drv = 1'b0;
      #HALF;
      scl_clk = 1'b0;
   endtask
   task automatic stop_cond();
      #4;
      sda_drv = 1'b0;
      #(HALF - 4);
      scl_clk = 1'b1;
      #HALF;
      sda_drv = 1'b1;
      #(HALF * 8);
   endtask
   task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
      output logic nak);
      logic [8:0] bits;
      bits = {tx, mack};
      for (int i = 8; i >= 0; i--) begin
         #4;
         sda_drv = bits[i];
         #(HALF - 4);
         scl_clk = 1'b1;
         if (i > 0) begin
            rx[i - 1] = sda_wire;
         end else begin
            nak = sda_wire;
         end
         #HALF;
         scl_clk = 1'b0;
      end
   endtask
   task automatic wr_reg(input logic [7:0] p, input logic [7:0] d, input logic with_d,
      output logic nak);
      logic [7:0] rx;
      logic n0, n1, n2;
      start_cond();
      xfer({DEV_ADDR, 1'b0}, 1'b1, rx, n0);
      xfer(p, 1'b1, rx, n1);
      n2 = 1'b0;
      if (with_d) begin
         xfer(d, 1'b1, rx, n2);
      end
      stop_cond();
      nak = n0 | n1 | n2;
   endtask
   task automatic rd_reg(input logic [7:0] p, output logic [7:0] d, output logic nak);
      logic [7:0] rx;
      logic n0, n1, n2;
      wr_reg(p, 8'h00, 1'b0, n0);
      start_cond();
      xfer({DEV_ADDR, 1'b1}, 1'b1, rx, n1);
      xfer(8'hff, 1'b1, d, n2);
      stop_cond();
      nak = n0 | n1;
   endtask
endmodule // bus_master_model
`default_nettype wire

// ---- bench/temp_monitor_register_bank_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module temp_monitor_register_bank_props #(
   parameter int TIMEOUT_LIMIT = 200
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic scl_clk,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic meas_valid,
   input wire temp_monitor_pkg::meas_t meas,
   input wire logic conv_busy,
   input wire logic standby,
   input wire logic one_shot_start,
   input wire logic [3:0] rate_code,
   input wire logic alert_out_n,
   input wire logic overtemp_out_n
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // ==========================
   // steps of the bus and trigger behaviour
   sequence s_scl_high;
      scl_clk ##1 scl_clk;
   endsequence
   sequence s_shot;
      one_shot_start ##1 !one_shot_start;
   endsequence
   a_sda_drive_low: assert property (sda_out == 1'b0)
      else $error("data pin value not low");
   a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl_clk)
      else $error("data pulled while clock high");
   a_oe_hold_high: assert property (s_scl_high |-> $stable(sda_oe))
      else $error("data drive changed in clock high");
   a_shot_one_cycle: assert property (one_shot_start |-> s_shot)
      else $error("trigger pulse too long");
   a_shot_in_standby: assert property (one_shot_start |-> standby)
      else $error("trigger outside standby");
   a_alert_after_meas: assert property ($fell(alert_out_n) |-> $past(meas_valid))
      else $error("alert without measurement");
   a_overtemp_after_meas: assert property ($fell(overtemp_out_n) |-> $past(meas_valid, 2))
      else $error("overtemp without measurement");
   a_release_values: assert property ($rose(rst_b) |-> rate_code == 4'h8 && !standby
      && alert_out_n && overtemp_out_n && !sda_oe)
      else $error("wrong values after reset");
endmodule // temp_monitor_register_bank_props
bind temp_monitor_register_bank temp_monitor_register_bank_props #(
   .TIMEOUT_LIMIT(TIMEOUT_LIMIT)
) u_props (.mclk(mclk), .rst_b(rst_b), .scl_clk(scl_clk), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .meas_valid(meas_valid), .meas(meas),
   .conv_busy(conv_busy), .standby(standby), .one_shot_start(one_shot_start),
   .rate_code(rate_code), .alert_out_n(alert_out_n), .overtemp_out_n(overtemp_out_n));
`default_nettype wire

// ---- bench/temp_monitor_register_bank_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module temp_monitor_register_bank_tb;
   localparam logic [7:0] MAKER = 8'h5a; // arbitrary value
   localparam logic [15:0] MAP [18] = '{16'h0000, 16'h0100, 16'h0300, 16'h0408, 16'h0555,
      16'h0600, 16'h0755, 16'h0800, 16'h1000, 16'h1100, 16'h1200, 16'h1300, 16'h1400,
      16'h2055, 16'h210a, 16'h2201, {8'hfe, MAKER}, 16'h3000};
   localparam logic [7:0] FILT [4] = '{8'h01, 8'h02, 8'h06, 8'h0e};
   logic mclk, rst_b, scl_clk, sda_drv, sda_out, sda_oe, meas_valid, conv_busy;
   logic standby, one_shot_start, alert_out_n, overtemp_out_n, nak;
   logic [3:0] rate_code;
   logic [7:0] got;
   temp_monitor_pkg::meas_t meas;
   int mismatches, n_tests;
   int shots = 0;
   wire sda_wire;
   assign sda_wire = sda_drv & ~sda_oe;
   temp_monitor_register_bank #(.TIMEOUT_LIMIT(200), .MAKER_CODE(MAKER))
   u_temp_monitor_register_bank (.mclk(mclk), .rst_b(rst_b), .scl_clk(scl_clk),
      .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .meas_valid(meas_valid),
      .meas(meas), .conv_busy(conv_busy), .standby(standby),
      .one_shot_start(one_shot_start), .rate_code(rate_code), .alert_out_n(alert_out_n),
      .overtemp_out_n(overtemp_out_n));
   bus_master_model u_bus_master_model (.sda_wire(sda_wire), .scl_clk(scl_clk),
      .sda_drv(sda_drv));
   always @(posedge mclk) if (one_shot_start === 1'b1) shots++;
   // ==========================
   // shared tasks
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected at %0t: got %h, expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      u_bus_master_model.wr_reg(p, d, 1'b1, nak);
      chk({7'h00, nak}, 8'h00);
   endtask
   task automatic rd_chk(input logic [7:0] p, input logic [7:0] e);
      u_bus_master_model.rd_reg(p, got, nak);
      chk({7'h00, nak}, 8'h00);
      chk(got, e);
   endtask
   task automatic send(input logic [7:0] l, input logic [9:0] r, input logic o);
      @(posedge mclk);
      #1;
      meas_valid = 1'b1;
      meas = {l, r, o};
      @(posedge mclk);
      #1;
      meas_valid = 1'b0;
      repeat (4) @(posedge mclk);
   endtask
   task automatic results();
      $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ==========================
   // scenarios
   task automatic t_reset_map();
      chk({4'h0, rate_code}, 8'h08);
      for (int i = 0; i < 18; i++) rd_chk(MAP[i][15:8], MAP[i][7:0]);
   endtask
   task automatic t_split();
      logic [7:0] v [6] = '{8'h40, 8'h05, 8'h50, 8'he0, 8'h50, 8'he0};
      for (int i = 0; i < 6; i++) wr(8'h09 + i[7:0], v[i]);
      for (int i = 0; i < 6; i++) rd_chk(8'h03 + i[7:0], v[i]);
      chk({4'h0, rate_code}, 8'h05);
      chk({7'h00, standby}, 8'h01);
      wr(8'h00, 8'h77);
      rd_chk(8'h00, 8'h00);
      @(posedge mclk);
      #1;
      conv_busy = 1'b1;
      rd_chk(8'h02, 8'h80);
      @(posedge mclk);
      #1;
      conv_busy = 1'b0;
   endtask
   task automatic t_one_shot();
      shots = 0;
      wr(8'h0f, 8'ha5);
      chk(shots[7:0], 8'h01);
      rd_chk(8'h0f, 8'h00);
      wr(8'h09, 8'h00);
      chk({7'h00, standby}, 8'h00);
      wr(8'h0f, 8'h5a);
      chk(shots[7:0], 8'h01);
   endtask
   task automatic t_filter();
      for (int k = 0; k < 4; k++) begin
         wr(8'h22, FILT[k]);
         send(8'h20, 10'h050, 1'b0);
         rd_chk(8'h02, (k == 0) ? 8'h00 : (k == 1) ? 8'h04 : 8'h40);
         chk({7'h00, alert_out_n}, 8'h01);
         for (int j = 0; j < k; j++) send(8'h60, 10'h050, k == 0);
         send(8'h20, 10'h050, 1'b0);
         for (int j = 0; j < k; j++) send(8'h60, 10'h050, k == 0);
         chk({7'h00, alert_out_n}, (k == 0) ? 8'h01 : 8'h01);
         send((k == 0) ? 8'h20 : 8'h60, 10'h050, k == 0);
         chk({7'h00, alert_out_n}, 8'h00);
      end
      rd_chk(8'h22, 8'h0e);
   endtask
   task automatic t_offset();
      wr(8'h11, 8'hfc);
      wr(8'h12, 8'hff);
      rd_chk(8'h12, 8'hc0);
      rd_chk(8'h11, 8'hfc);
      send(8'h20, 10'h050, 1'b0);
      rd_chk(8'h01, 8'h10);
      rd_chk(8'h10, 8'hc0);
      chk({7'h00, overtemp_out_n}, 8'h01);
      wr(8'h11, 8'h7f);
      wr(8'h12, 8'hc0);
      send(8'h20, 10'h1f0, 1'b0);
      rd_chk(8'h01, 8'h7f);
      rd_chk(8'h10, 8'hc0);
      chk({7'h00, overtemp_out_n}, 8'h00);
   endtask
   task automatic t_timeout(input logic en);
      logic n;
      u_bus_master_model.wr_reg(8'h00, 8'h00, 1'b0, n);
      u_bus_master_model.start_cond();
      u_bus_master_model.xfer(8'h99, 1'b1, got, n);
      repeat (300) @(posedge mclk);
      chk({7'h00, sda_oe}, {7'h00, !en});
      u_bus_master_model.xfer(8'hff, 1'b1, got, n);
      u_bus_master_model.stop_cond();
   endtask
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      #400000;
      mismatches++;
      $display("unexpected at %0t: run did not finish", $time);
      results();
   end
   initial begin
      rst_b = 1'b0;
      meas_valid = 1'b0;
      meas = '0;
      conv_busy = 1'b0;
      mismatches = 0;
      n_tests = 0;
      repeat (16) @(posedge mclk);
      #1;
      rst_b = 1'b1;
      repeat (3) @(posedge mclk);
      t_reset_map();
      t_split();
      t_one_shot();
      t_filter();
      t_timeout(1'b0);
      wr(8'h22, 8'h8e);
      t_timeout(1'b1);
      rd_chk(8'h22, 8'h8e);
      wr(8'h22, 8'h0e);
      t_offset();
      results();
   end
endmodule // temp_monitor_register_bank_tb
`default_nettype wire

// ---- verilog/temp_monitor_pkg.sv ----
`default_nettype none
package temp_monitor_pkg;
   // ==================================================
   // read addresses
   localparam logic [7:0] RD_LOCAL_TEMP = 8'h00;
   localparam logic [7:0] RD_REMOTE_UPPER = 8'h01;
   localparam logic [7:0] RD_FLAGS = 8'h02;
   localparam logic [7:0] RD_SETUP = 8'h03;
   localparam logic [7:0] RD_RATE = 8'h04;
   localparam logic [7:0] RD_LOCAL_HI = 8'h05;
   localparam logic [7:0] RD_LOCAL_LO = 8'h06;
   localparam logic [7:0] RD_REMOTE_HI_MSB = 8'h07;
   localparam logic [7:0] RD_REMOTE_LO_MSB = 8'h08;
   localparam logic [7:0] RD_REMOTE_LOWER = 8'h10;
   localparam logic [7:0] RD_MAKER = 8'hfe;
   localparam logic [7:0] RD_REVISION = 8'hff;
   // ==================================================
   // write addresses
   localparam logic [7:0] WR_SETUP = 8'h09;
   localparam logic [7:0] WR_RATE = 8'h0a;
   localparam logic [7:0] WR_LOCAL_HI = 8'h0b;
   localparam logic [7:0] WR_LOCAL_LO = 8'h0c;
   localparam logic [7:0] WR_REMOTE_HI_MSB = 8'h0d;
   localparam logic [7:0] WR_REMOTE_LO_MSB = 8'h0e;
   localparam logic [7:0] WR_ONE_SHOT = 8'h0f;
   // ==================================================
   // shared read/write addresses
   localparam logic [7:0] RW_OFFSET_UPPER = 8'h11;
   localparam logic [7:0] RW_OFFSET_LOWER = 8'h12;
   localparam logic [7:0] RW_REMOTE_HI_LSB = 8'h13;
   localparam logic [7:0] RW_REMOTE_LO_LSB = 8'h14;
   localparam logic [7:0] RW_REMOTE_OVERTEMP = 8'h19;
   localparam logic [7:0] RW_LOCAL_OVERTEMP = 8'h20;
   localparam logic [7:0] RW_HYSTERESIS = 8'h21;
   localparam logic [7:0] RW_FILTER_COUNT = 8'h22;
   // ==================================================
   // reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_RATE = 8'h08;
   localparam logic [7:0] RST_HIGH_BOUND = 8'h55;
   localparam logic [7:0] RST_OVERTEMP = 8'h55;
   localparam logic [7:0] RST_HYSTERESIS = 8'h0a;
   localparam logic [7:0] RST_FILTER_COUNT = 8'h01;
   // ==================================================
   // field positions
   localparam int STANDBY_BIT = 6;
   localparam int TIMEOUT_EN_BIT = 7;
   localparam int BUSY_BIT = 7;
   localparam int FRAC_HI_BIT = 7;
   localparam int FRAC_LO_BIT = 6;
   // ==================================================
   // timing
   localparam int CLK_KHZ = 200000;
   localparam int TIMEOUT_MS = 25;
   localparam int TIMEOUT_CYCLES = TIMEOUT_MS * CLK_KHZ;
   localparam logic [6:0] BUS_ADDR = 7'h4c;
   // ==================================================
   typedef struct packed {
      logic [7:0] local_temp;
      logic [9:0] remote_temp;
      logic open_sensor;
   } meas_t;
endpackage
`default_nettype wire

// ---- verilog/temp_monitor_register_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
module temp_monitor_register_bank #(
   parameter int TIMEOUT_LIMIT = temp_monitor_pkg::TIMEOUT_CYCLES,
   parameter logic [6:0] DEVICE_ADDR = temp_monitor_pkg::BUS_ADDR,
   parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
   parameter logic [7:0] REVISION_CODE = 8'h03 // arbitrary value
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic scl_clk,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic meas_valid,
   input wire temp_monitor_pkg::meas_t meas,
   input wire logic conv_busy,
   output logic standby,
   output logic one_shot_start,
   output logic [3:0] rate_code,
   output logic alert_out_n,
   output logic overtemp_out_n
);
   // elaboration check: the watchdog counter is 24 bits wide
   if (TIMEOUT_LIMIT < 1 || TIMEOUT_LIMIT > 16777215) begin : g_bad_timeout
      $error("TIMEOUT_LIMIT out of range");
   end

   // ==================================================
   // link clock domain: sample data on each rising clock
   logic link_bit;
   logic link_tgl;

   always_ff @(posedge scl_clk or negedge rst_b) begin
      if (!rst_b) begin
         link_bit <= 1'b0;
         link_tgl <= 1'b0;
      end else begin
         link_bit <= sda_in;
         link_tgl <= ~link_tgl;
      end
   end

   // ==================================================
   // crossings into mclk
   logic tgl_s1, tgl_s2, tgl_d;
   logic scl_s1, scl_s2, scl_d;
   logic sda_s1, sda_s2, sda_d;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tgl_s1 <= 1'b0;
         tgl_s2 <= 1'b0;
         tgl_d <= 1'b0;
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         tgl_s1 <= link_tgl;
         tgl_s2 <= tgl_s1;
         tgl_d <= tgl_s2;
         scl_s1 <= scl_clk;
         scl_s2 <= scl_s1;
         scl_d <= scl_s2;
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
         sda_d <= sda_s2;
      end
   end

   logic rise_evt, fall_evt, start_evt, stop_evt;
   assign rise_evt = tgl_s2 ^ tgl_d;
   assign fall_evt = scl_d & ~scl_s2;
   assign start_evt = scl_s2 & scl_d & sda_d & ~sda_s2;
   assign stop_evt = scl_s2 & scl_d & ~sda_d & sda_s2;

   // ==================================================
   // register storage
   logic [7:0] local_temp_value, remote_temp_value_upper, remote_temp_value_lower;
   logic [7:0] device_setup, sample_rate_select;
   logic [7:0] local_upper_bound, local_lower_bound;
   logic [7:0] remote_upper_bound_msb, remote_lower_bound_msb;
   logic [7:0] remote_upper_bound_lsb, remote_lower_bound_lsb;
   logic [7:0] remote_offset_upper, remote_offset_lower;
   logic [7:0] remote_overtemp_bound, local_overtemp_bound, overtemp_hysteresis;
   logic [7:0] alarm_filter_count;
   logic [7:0] register_select_pointer;
   logic [4:0] cond_flags, sticky_flags;
   logic local_hot, remote_hot;

   // ==================================================
   // bus engine
   typedef enum {st_idle, st_addr, st_cmd, st_data, st_read} bus_state_t;
   bus_state_t state;
   logic [3:0] bit_cnt;
   logic [7:0] shreg, tx;
   logic master_nack, wr_pulse, status_read;
   logic [7:0] wr_data;
   logic [7:0] rd_byte;
   logic [23:0] idle_cnt;
   logic timed_out;

   function automatic logic [7:0] read_value(input logic [7:0] ptr);
      logic [7:0] v;
      v = 8'h00;
      unique case (ptr)
         temp_monitor_pkg::RD_LOCAL_TEMP: v = local_temp_value;
         temp_monitor_pkg::RD_REMOTE_UPPER: v = remote_temp_value_upper;
         temp_monitor_pkg::RD_REMOTE_LOWER: v = remote_temp_value_lower;
         temp_monitor_pkg::RD_FLAGS: v = {conv_busy, sticky_flags, remote_hot, local_hot};
         temp_monitor_pkg::RD_SETUP: v = device_setup;
         temp_monitor_pkg::RD_RATE: v = sample_rate_select;
         temp_monitor_pkg::RD_LOCAL_HI: v = local_upper_bound;
         temp_monitor_pkg::RD_LOCAL_LO: v = local_lower_bound;
         temp_monitor_pkg::RD_REMOTE_HI_MSB: v = remote_upper_bound_msb;
         temp_monitor_pkg::RD_REMOTE_LO_MSB: v = remote_lower_bound_msb;
         temp_monitor_pkg::RW_OFFSET_UPPER: v = remote_offset_upper;
         temp_monitor_pkg::RW_OFFSET_LOWER: v = remote_offset_lower;
         temp_monitor_pkg::RW_REMOTE_HI_LSB: v = remote_upper_bound_lsb;
         temp_monitor_pkg::RW_REMOTE_LO_LSB: v = remote_lower_bound_lsb;
         temp_monitor_pkg::RW_REMOTE_OVERTEMP: v = remote_overtemp_bound;
         temp_monitor_pkg::RW_LOCAL_OVERTEMP: v = local_overtemp_bound;
         temp_monitor_pkg::RW_HYSTERESIS: v = overtemp_hysteresis;
         temp_monitor_pkg::RW_FILTER_COUNT: v = alarm_filter_count;
         temp_monitor_pkg::RD_MAKER: v = MAKER_CODE;
         temp_monitor_pkg::RD_REVISION: v = REVISION_CODE;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   always_comb rd_byte = read_value(register_select_pointer);

   // inactivity watchdog, only while a transaction is open
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         idle_cnt <= '0;
      end else if (state == st_idle || rise_evt || fall_evt ||
                   !alarm_filter_count[temp_monitor_pkg::TIMEOUT_EN_BIT]) begin
         idle_cnt <= '0;
      end else if (!timed_out) begin
         idle_cnt <= idle_cnt + 24'h000001;
      end
   end
   assign timed_out = (idle_cnt >= 24'(TIMEOUT_LIMIT - 1));

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state <= st_idle;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         tx <= 8'h00;
         master_nack <= 1'b0;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
         register_select_pointer <= 8'h00;
         wr_pulse <= 1'b0;
         wr_data <= 8'h00;
         status_read <= 1'b0;
      end else begin
         wr_pulse <= 1'b0;
         status_read <= 1'b0;
         if (start_evt) begin
            state <= st_addr;
            bit_cnt <= 4'h0;
            sda_oe <= 1'b0;
         end else if (stop_evt || timed_out) begin
            state <= st_idle;
            sda_oe <= 1'b0;
         end else if (state != st_idle && rise_evt) begin
            if (bit_cnt < 4'h8)
               shreg <= {shreg[6:0], link_bit};
            else
               master_nack <= link_bit;
            bit_cnt <= bit_cnt + 4'h1;
         end else if (state != st_idle && fall_evt) begin
            if (bit_cnt == 4'h8) begin
               unique case (state)
                  st_addr: begin
                     if (shreg[7:1] == DEVICE_ADDR) begin
                        sda_oe <= 1'b1;
                     end else begin
                        state <= st_idle;
                     end
                  end
                  st_cmd: begin
                     register_select_pointer <= shreg;
                     sda_oe <= 1'b1;
                  end
                  st_data: begin
                     wr_pulse <= 1'b1;
                     wr_data <= shreg;
                     sda_oe <= 1'b1;
                  end
                  default: sda_oe <= 1'b0;
               endcase
            end else if (bit_cnt == 4'h9) begin
               bit_cnt <= 4'h0;
               sda_oe <= 1'b0;
               if ((state == st_addr && shreg[0]) || (state == st_read && !master_nack)) begin
                  state <= st_read;
                  tx <= rd_byte;
                  sda_oe <= ~rd_byte[7];
                  status_read <= (register_select_pointer == temp_monitor_pkg::RD_FLAGS);
               end else if (state == st_read) begin
                  state <= st_idle;
               end else if (state == st_addr) begin
                  state <= st_cmd;
               end else begin
                  state <= st_data;
               end
            end else if (state == st_read) begin
               sda_oe <= ~tx[3'(7 - bit_cnt)];
            end
         end
      end
   end

   // ==================================================
   // register writes
   logic one_shot_hit;
   assign one_shot_hit = wr_pulse && register_select_pointer == temp_monitor_pkg::WR_ONE_SHOT;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         device_setup <= temp_monitor_pkg::RST_ZERO;
         sample_rate_select <= temp_monitor_pkg::RST_RATE;
         local_upper_bound <= temp_monitor_pkg::RST_HIGH_BOUND;
         local_lower_bound <= temp_monitor_pkg::RST_ZERO;
         remote_upper_bound_msb <= temp_monitor_pkg::RST_HIGH_BOUND;
         remote_lower_bound_msb <= temp_monitor_pkg::RST_ZERO;
         remote_upper_bound_lsb <= temp_monitor_pkg::RST_ZERO;
         remote_lower_bound_lsb <= temp_monitor_pkg::RST_ZERO;
         remote_offset_upper <= temp_monitor_pkg::RST_ZERO;
         remote_offset_lower <= temp_monitor_pkg::RST_ZERO;
         remote_overtemp_bound <= temp_monitor_pkg::RST_OVERTEMP;
         local_overtemp_bound <= temp_monitor_pkg::RST_OVERTEMP;
         overtemp_hysteresis <= temp_monitor_pkg::RST_HYSTERESIS;
         alarm_filter_count <= temp_monitor_pkg::RST_FILTER_COUNT;
      end else if (wr_pulse) begin
         unique case (register_select_pointer)
            temp_monitor_pkg::WR_SETUP: device_setup <= wr_data;
            temp_monitor_pkg::WR_RATE: sample_rate_select <= wr_data;
            temp_monitor_pkg::WR_LOCAL_HI: local_upper_bound <= wr_data;
            temp_monitor_pkg::WR_LOCAL_LO: local_lower_bound <= wr_data;
            temp_monitor_pkg::WR_REMOTE_HI_MSB: remote_upper_bound_msb <= wr_data;
            temp_monitor_pkg::WR_REMOTE_LO_MSB: remote_lower_bound_msb <= wr_data;
            temp_monitor_pkg::RW_REMOTE_HI_LSB: remote_upper_bound_lsb <= wr_data;
            temp_monitor_pkg::RW_REMOTE_LO_LSB: remote_lower_bound_lsb <= wr_data;
            temp_monitor_pkg::RW_OFFSET_UPPER: remote_offset_upper <= wr_data;
            temp_monitor_pkg::RW_OFFSET_LOWER: remote_offset_lower <= {wr_data[7:6], 6'h00};
            temp_monitor_pkg::RW_REMOTE_OVERTEMP: remote_overtemp_bound <= wr_data;
            temp_monitor_pkg::RW_LOCAL_OVERTEMP: local_overtemp_bound <= wr_data;
            temp_monitor_pkg::RW_HYSTERESIS: overtemp_hysteresis <= wr_data;
            temp_monitor_pkg::RW_FILTER_COUNT: alarm_filter_count <= wr_data;
            default: ;
         endcase
      end
   end

   // ==================================================
   // conversion control
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         standby <= 1'b0;
         one_shot_start <= 1'b0;
         rate_code <= temp_monitor_pkg::RST_RATE[3:0];
      end else begin
         standby <= device_setup[temp_monitor_pkg::STANDBY_BIT];
         one_shot_start <= one_shot_hit && device_setup[temp_monitor_pkg::STANDBY_BIT];
         rate_code <= sample_rate_select[3:0];
      end
   end

   // ==================================================
   // offset correction and limit checks
   logic signed [10:0] sum;
   logic [9:0] next_remote;
   logic signed [9:0] rem_hi, rem_lo;
   logic [4:0] next_cond;
   logic [2:0] run_cnt, next_run, thresh;

   always_comb begin
      sum = 11'($signed(meas.remote_temp)) +
            11'($signed({remote_offset_upper,
                         remote_offset_lower[temp_monitor_pkg::FRAC_HI_BIT:
                                             temp_monitor_pkg::FRAC_LO_BIT]}));
      if (sum[10] != sum[9])
         next_remote = sum[10] ? 10'h200 : 10'h1ff;
      else
         next_remote = sum[9:0];
   end

   assign rem_hi = $signed({remote_upper_bound_msb, remote_upper_bound_lsb[7:6]});
   assign rem_lo = $signed({remote_lower_bound_msb, remote_lower_bound_lsb[7:6]});
   assign next_cond = {$signed(meas.local_temp) > $signed(local_upper_bound),
                       $signed(meas.local_temp) <= $signed(local_lower_bound),
                       $signed(next_remote) > rem_hi,
                       $signed(next_remote) <= rem_lo,
                       meas.open_sensor};
   assign next_run = (run_cnt == 3'h4) ? 3'h4 : run_cnt + 3'h1;
   assign thresh = 3'h1 + {2'h0, alarm_filter_count[1]} +
                   {2'h0, alarm_filter_count[2]} + {2'h0, alarm_filter_count[3]};

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         local_temp_value <= temp_monitor_pkg::RST_ZERO;
         remote_temp_value_upper <= temp_monitor_pkg::RST_ZERO;
         remote_temp_value_lower <= temp_monitor_pkg::RST_ZERO;
         cond_flags <= 5'h00;
         run_cnt <= 3'h0;
      end else if (meas_valid) begin
         local_temp_value <= meas.local_temp;
         remote_temp_value_upper <= next_remote[9:2];
         remote_temp_value_lower <= {next_remote[1:0], 6'h00};
         cond_flags <= next_cond;
         run_cnt <= (|next_cond) ? next_run : 3'h0;
      end
   end

   // ==================================================
   // sticky flags and alert latch; a set wins over a clear
   logic alert_latch, alert_set, alert_clr;
   logic [4:0] flag_clr;
   assign flag_clr = status_read ? ~cond_flags : 5'h00;
   assign alert_set = meas_valid && (|next_cond) && (next_run >= thresh);
   assign alert_clr = status_read && cond_flags == 5'h00;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sticky_flags <= 5'h00;
         alert_latch <= 1'b0;
         alert_out_n <= 1'b1;
      end else begin
         sticky_flags <= (sticky_flags & ~flag_clr) | (meas_valid ? next_cond : 5'h00);
         if (alert_set)
            alert_latch <= 1'b1;
         else if (alert_clr)
            alert_latch <= 1'b0;
         alert_out_n <= ~(alert_latch | alert_set);
      end
   end

   // ==================================================
   // overtemp comparators with hysteresis
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         local_hot <= 1'b0;
         remote_hot <= 1'b0;
         overtemp_out_n <= 1'b1;
      end else begin
         if (meas_valid) begin
            if ($signed(meas.local_temp) > $signed(local_overtemp_bound))
               local_hot <= 1'b1;
            else if ($signed(meas.local_temp) <=
                     $signed(local_overtemp_bound - overtemp_hysteresis))
               local_hot <= 1'b0;
            if ($signed(next_remote[9:2]) > $signed(remote_overtemp_bound))
               remote_hot <= 1'b1;
            else if ($signed(next_remote[9:2]) <=
                     $signed(remote_overtemp_bound - overtemp_hysteresis))
               remote_hot <= 1'b0;
         end
         overtemp_out_n <= ~(local_hot | remote_hot);
      end
   end
endmodule // temp_monitor_register_bank
`default_nettype wire
